// ### hdl/hdlc_irq_pkg.sv
// Constants, field positions and carrier types of the HDLC interrupt status block.
// Assumes one clock domain and a plain strobe register port with 7-bit byte addresses.
package hdlc_irq_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 7;                        // Byte address width
  localparam logic [6:0] CH_STRIDE = 7'h40;         // Channel B offset
  localparam logic [6:0] OFS_MODE = 7'h30;          // Channel mode bits
  localparam logic [6:0] OFS_MASK0 = 7'h34;         // Receive event mask
  localparam logic [6:0] OFS_MASK1 = 7'h35;         // Transmit/loop event mask
  localparam logic [6:0] OFS_LINE = 7'h36;          // Live line state
  localparam logic [6:0] OFS_RX_STAT = 7'h3A;       // Receive event status
  localparam logic [6:0] OFS_TX_STAT = 7'h3B;       // Transmit/loop event status
  localparam logic [6:0] ADR_GCFG = 7'h38;          // Global config, visibility
  localparam logic [6:0] ADR_GSUM = 7'h39;          // Global event summary
  localparam logic [7:0] ISR_RESET = 8'h00;         // Status reset value
  localparam logic [7:0] RD_UNMAPPED = 8'h00;       // Unmapped read answer

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int B0_MSG_END = 7;
  localparam int B0_FRM_START = 6;
  localparam int B0_REMOTE = 5;
  localparam int B0_PROTO = 4;
  localparam int B0_SYNC = 3;
  localparam int B0_CARRIER = 2;
  localparam int B0_FRM_OVF = 1;
  localparam int B0_POOL = 0;
  localparam int B1_POLL_END = 7;
  localparam int B1_LOOP_OVF = 6;
  localparam int B1_ACTIVE_SENT = 5;
  localparam int B1_UNDERRUN = 4;
  localparam int B1_TIMER = 3;
  localparam int B1_CTS = 2;
  localparam int B1_REPEAT = 1;
  localparam int B1_POOL_RDY = 0;
  localparam int M_AUTO = 0;
  localparam int M_INTMODE = 1;
  localparam int M_LOOP = 2;
  localparam int M_DPLL_RX = 3;
  localparam int M_DPLL_CODE = 4;
  localparam int M_DPLL_TX = 5;

  // ----------------------------------------------------------------
  // Counts and vector codes
  // ----------------------------------------------------------------
  localparam logic [5:0] POOL_BYTES = 6'h20;        // Receive pool size
  localparam logic [1:0] START_DELAY = 2'h2;        // Bytes after frame start
  localparam logic [7:0] VEC_A_MSG_END = 8'h07;     // Vector {ch,reg,bit}

  // Loop state, Gray along off-wait-on-active
  typedef enum logic [1:0] {
    LOOP_OFF = 2'h0,
    LOOP_WAIT = 2'h1,
    LOOP_ON = 2'h3,
    LOOP_ACTIVE = 2'h2
  } loop_e;

  // Per-channel events and levels from the receiver and transmitter
  typedef struct packed {
    logic byte_valid;
    logic [7:0] byte_data;
    logic frame_end;
    logic [7:0] frame_status;
    logic start_detect;
    logic [7:0] header;
    logic [7:0] address;
    logic sup_rx;
    logic sup_rnr;
    logic nr_error;
    logic s_with_i;
    logic dpll_locked;
    logic carrier;
    logic fifo_full;
    logic poll_end_rx;
    logic go_on_loop;
    logic go_active;
    logic leave_active;
    logic rx_overflow;
    logic all_sent;
    logic tx_underrun;
    logic timer_expiry;
    logic cts;
    logic repeat_req;
    logic pool_ready;
    logic rx_bit;
    logic bit_strobe;
  } chan_in_s;

  // Per-channel registered outputs
  typedef struct packed {
    logic fifo_push;
    logic [7:0] fifo_data;
    logic [4:0] byte_count;
    logic [7:0] hdr_copy;
    logic [7:0] addr_byte;
    logic [3:0] status_low;
    logic rx_enable;
    logic tx_hold;
    logic txd;
    logic on_loop;
  } chan_out_s;

endpackage : hdlc_irq_pkg

// ### hdl/hdlc_interrupt_status.sv
// Two-channel HDLC interrupt status: event flags, masks, vectors and loop repeat.
// Assumes event inputs are one-cycle pulses synchronous to clock, levels are synchronous.
//
// Operation
// - Receive status at 3A/7A, zero after reset
// - Transmit status at 3B/7B, zero after reset
// - Reading receive status clears all bits
// - Vector output clears message end, pool full
// - Visibility on: masked events flag, no interrupt
// - Message end when frame tail stored
// - Append status byte, expose stored count
// - Frame start flag two bytes after start
// - Header, address, status nibble valid at flag
// - Auto mode: remote ready change flagged
// - Auto mode: bad N(R) or S-frame I-field
// - DPLL coding: flag synchronisation loss
// - Unsynchronised DPLL disables receive, holds transmit
// - Carrier edge flags, level readable
// - Whole frame discarded flags overflow
// - Interrupt mode: 32 bytes unfinished frame
// - Reading transmit status clears; vector clears pool ready
// - Transmit status bits 7..5 change meaning in loop mode
// - Visibility applies to transmit status too
// - Loop mode: end-of-poll flagged
// - On-loop after command plus poll end
// - On loop, repeat RxD with one bit delay
`timescale 1ns/1ps

module hdlc_interrupt_status
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [6:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic ack,
  output logic vec_valid,
  output logic [7:0] vec,
  output logic irq,
  input wire hdlc_irq_pkg::chan_in_s [1:0] chan_in,
  output hdlc_irq_pkg::chan_out_s [1:0] chan_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] rx_stat;                // Receive event status
    logic [7:0] tx_stat;                // Transmit/loop event status
    logic [7:0] mask0;                  // One masks a receive event
    logic [7:0] mask1;                  // One masks a transmit event
    logic [5:0] mode;                   // Channel mode bits
    logic cd;                           // Last carrier level
    logic cts;                          // Last clear-to-send level
    logic lock;                         // Last DPLL lock level
    logic rnr;                          // Remote not ready
    logic [5:0] cnt;                    // Bytes of current pool block
    logic [1:0] start_cnt;              // Bytes since frame start
    logic discard;                      // Current frame dropped
    logic stored_any;                   // Current frame has a stored byte
    logic active_arm;                   // Go-active awaiting poll end
    hdlc_irq_pkg::loop_e loop;          // Loop state
    hdlc_irq_pkg::chan_out_s o;         // Registered outputs
  } chan_s;

  typedef struct packed {
    chan_s [1:0] ch;
    logic mask_vis;                     // Masked events still flag
    logic [7:0] rdata;
    logic irq;
    logic vec_valid;
    logic [7:0] vec;
  } state_s;

  state_s state_ff;
  state_s nxt_state;
  logic [1:0][7:0] ev0;                 // Raw receive events this cycle
  logic [1:0][7:0] ev1;                 // Raw transmit events this cycle
  logic [1:0] byte_ok;                  // Data byte stored this cycle
  logic any_pend;                       // Unmasked pending anywhere

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Highest set bit: {found, index}
  function automatic logic [3:0] top_bit(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 8; i++)
    begin
      if (v[i])
        r = {1'b1, i[2:0]};
    end
    return r;
  endfunction : top_bit

  // Per-channel register match
  function automatic logic reg_hit(input logic [6:0] a, input logic c, input logic [6:0] ofs);
    return a == (c ? ofs + hdlc_irq_pkg::CH_STRIDE : ofs);
  endfunction : reg_hit

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Events, register access, vectoring and loop control
  always_comb
  begin
    logic [7:0] gate0;
    logic [7:0] gate1;
    logic [7:0] clr0;
    logic [7:0] clr1;
    logic dpll_on;
    logic loop_md;
    logic done;
    logic [3:0] tb;
    nxt_state = state_ff;
    gate0 = 8'h00;
    gate1 = 8'h00;
    clr0 = 8'h00;
    clr1 = 8'h00;
    dpll_on = 1'b0;
    loop_md = 1'b0;
    done = 1'b0;
    tb = 4'h0;
    ev0 = '0;
    ev1 = '0;
    byte_ok = 2'h0;
    any_pend = 1'b0;
    nxt_state.vec_valid = 1'b0;
    nxt_state.rdata = hdlc_irq_pkg::RD_UNMAPPED;
    // Global registers
    if (wr_en && addr == hdlc_irq_pkg::ADR_GCFG)
      nxt_state.mask_vis = wr_data[0];
    if (rd_en && addr == hdlc_irq_pkg::ADR_GCFG)
      nxt_state.rdata = {7'h00, state_ff.mask_vis};
    // Interrupt vector on acknowledge, channel A first, receive first
    for (int c = 0; c < 2; c++)
    begin
      tb = top_bit(state_ff.ch[c].rx_stat & ~state_ff.ch[c].mask0);
      if (ack && !done && tb[3])
      begin
        done = 1'b1;
        nxt_state.vec_valid = 1'b1;
        nxt_state.vec = {3'h0, c[0], 1'b0, tb[2:0]};
      end
      tb = top_bit(state_ff.ch[c].tx_stat & ~state_ff.ch[c].mask1);
      if (ack && !done && tb[3])
      begin
        done = 1'b1;
        nxt_state.vec_valid = 1'b1;
        nxt_state.vec = {3'h0, c[0], 1'b1, tb[2:0]};
      end
    end
    for (int c = 0; c < 2; c++)
    begin
      dpll_on = state_ff.ch[c].mode[hdlc_irq_pkg::M_DPLL_RX] && state_ff.ch[c].mode[hdlc_irq_pkg::M_DPLL_CODE];
      loop_md = state_ff.ch[c].mode[hdlc_irq_pkg::M_LOOP];
      nxt_state.ch[c].o.fifo_push = 1'b0;
      // Receive FIFO feed: whole frame dropped if full at its first byte
      if (chan_in[c].byte_valid)
      begin
        if (!state_ff.ch[c].stored_any && chan_in[c].fifo_full)
          nxt_state.ch[c].discard = 1'b1;
        else if (!state_ff.ch[c].discard && !chan_in[c].fifo_full)
          byte_ok[c] = 1'b1;
      end
      if (byte_ok[c])
      begin
        nxt_state.ch[c].o.fifo_push = 1'b1;
        nxt_state.ch[c].o.fifo_data = chan_in[c].byte_data;
        nxt_state.ch[c].stored_any = 1'b1;
        // Pool of 32 bytes of an unfinished frame
        if (state_ff.ch[c].cnt == hdlc_irq_pkg::POOL_BYTES - 6'h01)
        begin
          nxt_state.ch[c].cnt = 6'h00;
          ev0[c][hdlc_irq_pkg::B0_POOL] = state_ff.ch[c].mode[hdlc_irq_pkg::M_INTMODE];
        end
        else
          nxt_state.ch[c].cnt = state_ff.ch[c].cnt + 6'h01;
      end
      // Frame start raised after two stored bytes, snapshots taken together
      if (chan_in[c].start_detect)
        nxt_state.ch[c].start_cnt = 2'h1;
      else if (byte_ok[c] && state_ff.ch[c].start_cnt != 2'h0)
      begin
        if (state_ff.ch[c].start_cnt == hdlc_irq_pkg::START_DELAY)
        begin
          nxt_state.ch[c].start_cnt = 2'h0;
          ev0[c][hdlc_irq_pkg::B0_FRM_START] = 1'b1;
          nxt_state.ch[c].o.hdr_copy = chan_in[c].header;
          nxt_state.ch[c].o.addr_byte = chan_in[c].address;
          nxt_state.ch[c].o.status_low = chan_in[c].frame_status[3:0];
        end
        else
          nxt_state.ch[c].start_cnt = state_ff.ch[c].start_cnt + 2'h1;
      end
      // Frame end: status byte appended, message end or overflow
      if (chan_in[c].frame_end)
      begin
        nxt_state.ch[c].stored_any = 1'b0;
        nxt_state.ch[c].discard = 1'b0;
        nxt_state.ch[c].start_cnt = 2'h0;
        nxt_state.ch[c].cnt = 6'h00;
        if (state_ff.ch[c].discard)
          ev0[c][hdlc_irq_pkg::B0_FRM_OVF] = 1'b1;
        else
        begin
          nxt_state.ch[c].o.fifo_push = 1'b1;
          nxt_state.ch[c].o.fifo_data = chan_in[c].frame_status;
          ev0[c][hdlc_irq_pkg::B0_MSG_END] = 1'b1;
        end
      end
      nxt_state.ch[c].o.byte_count = nxt_state.ch[c].cnt[4:0];
      // Auto mode supervisory events
      if (state_ff.ch[c].mode[hdlc_irq_pkg::M_AUTO])
      begin
        if (chan_in[c].sup_rx && chan_in[c].sup_rnr != state_ff.ch[c].rnr)
        begin
          nxt_state.ch[c].rnr = chan_in[c].sup_rnr;
          ev0[c][hdlc_irq_pkg::B0_REMOTE] = 1'b1;
        end
        ev0[c][hdlc_irq_pkg::B0_PROTO] = chan_in[c].nr_error || chan_in[c].s_with_i;
      end
      // DPLL lock loss and its effect on the data paths
      nxt_state.ch[c].lock = chan_in[c].dpll_locked;
      ev0[c][hdlc_irq_pkg::B0_SYNC] = dpll_on && state_ff.ch[c].lock && !chan_in[c].dpll_locked;
      nxt_state.ch[c].o.rx_enable = !(dpll_on && !chan_in[c].dpll_locked);
      nxt_state.ch[c].o.tx_hold = dpll_on && state_ff.ch[c].mode[hdlc_irq_pkg::M_DPLL_TX]
                                  && !chan_in[c].dpll_locked;
      // Line level changes
      nxt_state.ch[c].cd = chan_in[c].carrier;
      ev0[c][hdlc_irq_pkg::B0_CARRIER] = chan_in[c].carrier != state_ff.ch[c].cd;
      nxt_state.ch[c].cts = chan_in[c].cts;
      ev1[c][hdlc_irq_pkg::B1_CTS] = chan_in[c].cts != state_ff.ch[c].cts;
      ev1[c][hdlc_irq_pkg::B1_UNDERRUN] = chan_in[c].tx_underrun;
      ev1[c][hdlc_irq_pkg::B1_TIMER] = chan_in[c].timer_expiry;
      ev1[c][hdlc_irq_pkg::B1_REPEAT] = chan_in[c].repeat_req;
      ev1[c][hdlc_irq_pkg::B1_POOL_RDY] = chan_in[c].pool_ready;
      // Loop mode state machine, bits 7..5 change meaning
      if (!loop_md)
      begin
        nxt_state.ch[c].loop = hdlc_irq_pkg::LOOP_OFF;
        nxt_state.ch[c].active_arm = 1'b0;
        ev1[c][hdlc_irq_pkg::B1_LOOP_OVF] = chan_in[c].rx_overflow;
        ev1[c][hdlc_irq_pkg::B1_ACTIVE_SENT] = chan_in[c].all_sent;
      end
      else
      begin
        ev1[c][hdlc_irq_pkg::B1_POLL_END] = chan_in[c].poll_end_rx;
        case (state_ff.ch[c].loop)
          hdlc_irq_pkg::LOOP_OFF:
          begin
            if (chan_in[c].go_on_loop)
              nxt_state.ch[c].loop = hdlc_irq_pkg::LOOP_WAIT;
          end
          hdlc_irq_pkg::LOOP_WAIT:
          begin
            // Go-on-loop takes effect only at poll end
            if (chan_in[c].poll_end_rx)
            begin
              nxt_state.ch[c].loop = hdlc_irq_pkg::LOOP_ON;
              ev1[c][hdlc_irq_pkg::B1_LOOP_OVF] = 1'b1;
            end
          end
          hdlc_irq_pkg::LOOP_ON:
          begin
            if (chan_in[c].go_active)
              nxt_state.ch[c].active_arm = 1'b1;
            if (chan_in[c].poll_end_rx && state_ff.ch[c].active_arm)
            begin
              nxt_state.ch[c].active_arm = 1'b0;
              nxt_state.ch[c].loop = hdlc_irq_pkg::LOOP_ACTIVE;
              ev1[c][hdlc_irq_pkg::B1_ACTIVE_SENT] = 1'b1;
            end
          end
          hdlc_irq_pkg::LOOP_ACTIVE:
          begin
            // Back to repeating also flags on-loop
            if (chan_in[c].leave_active)
            begin
              nxt_state.ch[c].loop = hdlc_irq_pkg::LOOP_ON;
              ev1[c][hdlc_irq_pkg::B1_LOOP_OVF] = 1'b1;
            end
          end
          default:
          begin
            nxt_state.ch[c].loop = hdlc_irq_pkg::LOOP_OFF;
          end
        endcase
      end
      // Bit repeater with one bit period delay
      nxt_state.ch[c].o.on_loop = nxt_state.ch[c].loop == hdlc_irq_pkg::LOOP_ON;
      if (state_ff.ch[c].loop != hdlc_irq_pkg::LOOP_ON)
        nxt_state.ch[c].o.txd = 1'b1;
      else if (chan_in[c].bit_strobe)
        nxt_state.ch[c].o.txd = chan_in[c].rx_bit;
      // Per-channel registers
      if (wr_en && reg_hit(addr, c[0], hdlc_irq_pkg::OFS_MODE))
        nxt_state.ch[c].mode = wr_data[5:0];
      if (wr_en && reg_hit(addr, c[0], hdlc_irq_pkg::OFS_MASK0))
        nxt_state.ch[c].mask0 = wr_data;
      if (wr_en && reg_hit(addr, c[0], hdlc_irq_pkg::OFS_MASK1))
        nxt_state.ch[c].mask1 = wr_data;
      if (rd_en && reg_hit(addr, c[0], hdlc_irq_pkg::OFS_MODE))
        nxt_state.rdata = {2'h0, state_ff.ch[c].mode};
      if (rd_en && reg_hit(addr, c[0], hdlc_irq_pkg::OFS_MASK0))
        nxt_state.rdata = state_ff.ch[c].mask0;
      if (rd_en && reg_hit(addr, c[0], hdlc_irq_pkg::OFS_MASK1))
        nxt_state.rdata = state_ff.ch[c].mask1;
      if (rd_en && reg_hit(addr, c[0], hdlc_irq_pkg::OFS_LINE))
        nxt_state.rdata = {3'h0, state_ff.ch[c].loop == hdlc_irq_pkg::LOOP_ON, state_ff.ch[c].cts,
                           !state_ff.ch[c].lock, state_ff.ch[c].rnr, state_ff.ch[c].cd};
      // Status reads return old contents then clear
      clr0 = 8'h00;
      clr1 = 8'h00;
      if (rd_en && reg_hit(addr, c[0], hdlc_irq_pkg::OFS_RX_STAT))
      begin
        nxt_state.rdata = state_ff.ch[c].rx_stat;
        clr0 = 8'hFF;
      end
      if (rd_en && reg_hit(addr, c[0], hdlc_irq_pkg::OFS_TX_STAT))
      begin
        nxt_state.rdata = state_ff.ch[c].tx_stat;
        clr1 = 8'hFF;
      end
      // Vector output clears its self-clearing source
      if (nxt_state.vec_valid && nxt_state.vec[4] == c[0])
      begin
        if (!nxt_state.vec[3] && (nxt_state.vec[2:0] == 3'h7 || nxt_state.vec[2:0] == 3'h0))
          clr0[nxt_state.vec[2:0]] = 1'b1;
        if (nxt_state.vec[3] && nxt_state.vec[2:0] == 3'h0)
          clr1[hdlc_irq_pkg::B1_POOL_RDY] = 1'b1;
      end
      // Masked events set only with visibility on; set beats clear
      gate0 = ev0[c] & ({8{state_ff.mask_vis}} | ~state_ff.ch[c].mask0);
      gate1 = ev1[c] & ({8{state_ff.mask_vis}} | ~state_ff.ch[c].mask1);
      nxt_state.ch[c].rx_stat = (state_ff.ch[c].rx_stat & ~clr0) | gate0;
      nxt_state.ch[c].tx_stat = (state_ff.ch[c].tx_stat & ~clr1) | gate1;
      // Pending uses the masks that stand after this edge, so a mask write never leaves irq stale
      any_pend = any_pend || |(nxt_state.ch[c].rx_stat & ~nxt_state.ch[c].mask0)
                 || |(nxt_state.ch[c].tx_stat & ~nxt_state.ch[c].mask1);
    end
    // Global summary hides masked statuses
    if (rd_en && addr == hdlc_irq_pkg::ADR_GSUM)
      nxt_state.rdata = {4'h0, |(state_ff.ch[1].tx_stat & ~state_ff.ch[1].mask1),
                         |(state_ff.ch[1].rx_stat & ~state_ff.ch[1].mask0),
                         |(state_ff.ch[0].tx_stat & ~state_ff.ch[0].mask1),
                         |(state_ff.ch[0].rx_stat & ~state_ff.ch[0].mask0)};
    nxt_state.irq = any_pend;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Whole state, constant reset
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  // Outputs straight from flip-flops
  assign rd_data = state_ff.rdata;
  assign irq = state_ff.irq;
  assign vec_valid = state_ff.vec_valid;
  assign vec = state_ff.vec;
  assign chan_out[0] = state_ff.ch[0].o;
  assign chan_out[1] = state_ff.ch[1].o;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_rd_rx_stat_a;
    rd_en && addr == hdlc_irq_pkg::OFS_RX_STAT;
  endsequence

  sequence s_rd_tx_stat_b;
    rd_en && addr == hdlc_irq_pkg::OFS_TX_STAT + hdlc_irq_pkg::CH_STRIDE;
  endsequence

  a_rx_stat_read:
    assert property (s_rd_rx_stat_a |=> rd_data == $past(state_ff.ch[0].rx_stat))
      else $error("receive status read data wrong");

  a_tx_stat_read:
    assert property (s_rd_tx_stat_b |=> rd_data == $past(state_ff.ch[1].tx_stat))
      else $error("transmit status read data wrong");

  a_read_clears_rx:
    assert property (s_rd_rx_stat_a ##0 ev0[0] == 8'h00 |=> state_ff.ch[0].rx_stat == 8'h00)
      else $error("receive status not cleared by read");

  a_vector_clears_end:
    assert property (vec_valid && vec == hdlc_irq_pkg::VEC_A_MSG_END && !$past(ev0[0][7])
                     |-> !state_ff.ch[0].rx_stat[hdlc_irq_pkg::B0_MSG_END])
      else $error("message end survived its vector");

  a_irq_tracks_status:
    assert property (irq == (|(state_ff.ch[0].rx_stat & ~state_ff.ch[0].mask0)
                     || |(state_ff.ch[0].tx_stat & ~state_ff.ch[0].mask1)
                     || |(state_ff.ch[1].rx_stat & ~state_ff.ch[1].mask0)
                     || |(state_ff.ch[1].tx_stat & ~state_ff.ch[1].mask1)))
      else $error("interrupt differs from unmasked status");

  a_carrier_flag:
    assert property (chan_in[0].carrier != state_ff.ch[0].cd && !state_ff.ch[0].mask0[2]
                     |=> state_ff.ch[0].rx_stat[hdlc_irq_pkg::B0_CARRIER])
      else $error("carrier change not flagged");

  a_frame_start_snap:
    assert property (byte_ok[0] && state_ff.ch[0].start_cnt == 2'h2 && !chan_in[0].start_detect
                     && !chan_in[0].frame_end && (state_ff.mask_vis || !state_ff.ch[0].mask0[6])
                     |=> state_ff.ch[0].rx_stat[6] && chan_out[0].hdr_copy == $past(chan_in[0].header))
      else $error("frame start flag or header snapshot missing");

  a_dpll_rx_off:
    assert property (state_ff.ch[0].mode[3] && state_ff.ch[0].mode[4] && !chan_in[0].dpll_locked
                     |=> !chan_out[0].rx_enable)
      else $error("receiver left enabled without lock");

  a_loop_repeat:
    assert property (state_ff.ch[0].loop == hdlc_irq_pkg::LOOP_ON && chan_in[0].bit_strobe
                     |=> chan_out[0].txd == $past(chan_in[0].rx_bit))
      else $error("loop repeat bit wrong");

  a_olp_needs_eop:
    assert property (state_ff.ch[0].loop == hdlc_irq_pkg::LOOP_WAIT && !chan_in[0].poll_end_rx
                     && state_ff.ch[0].mode[2] |=> state_ff.ch[0].loop == hdlc_irq_pkg::LOOP_WAIT)
      else $error("went on loop without poll end");

endmodule : hdlc_interrupt_status

// ### tb/host_model.sv
// Host model: a CPU driving the register port of the status block.
// Assumes one clock; the bench calls its tasks in turn.
`timescale 1ns/1ps
module host_model
(
  input wire logic clock,
  output logic [6:0] addr,
  output logic [7:0] wr_data,
  output logic wr_en,
  output logic rd_en,
  input wire logic [7:0] rd_data
);
  // Bus idle from time zero
  initial
  begin
    addr = 7'h00;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  // One-cycle write strobe
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr
  // Read strobe; data stands one cycle later only
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask : rd
endmodule : host_model

// ### tb/testbench.sv
// Bench: host reads status, events driven on channel inputs.
// Assumes the package and host model are compiled first.
`timescale 1ns/1ps
module testbench;
  logic clock, sys_rst, ack, wr_en, rd_en, irq, vec_valid;
  logic [6:0] addr;
  logic [7:0] wr_data, rd_data, vec, d;
  hdlc_irq_pkg::chan_in_s [1:0] chan_in;
  hdlc_irq_pkg::chan_out_s [1:0] chan_out;
  int n_mismatch = 0;
  int check_count = 0;
  hdlc_interrupt_status hdlc_interrupt_status_i (.clock(clock), .sys_rst(sys_rst),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .ack(ack), .vec_valid(vec_valid), .vec(vec), .irq(irq), .chan_in(chan_in), .chan_out(chan_out));
  host_model host_model_i (.clock(clock), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data));
  // 4 ns clock
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Compare one byte
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  // Read a register and compare
  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    host_model_i.rd(a, d);
    chk("register", exp, d);
  endtask : rchk
  // Counts, verdict, stop
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  // Hang guard, tests need about 60 cycles
  initial
  begin
    #4000;
    n_mismatch++;
    end_of_test();
  end
  // ------------------------------------------
  // Tests
  // ------------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    ack = 1'b0;
    chan_in = '0;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    rchk(7'h3A, 8'h00);
    rchk(7'h7A, 8'h00);
    rchk(7'h3B, 8'h00);
    rchk(7'h7B, 8'h00);
    rchk(7'h20, 8'h00);
    $display("test reset done");
    // Carrier edge flags bit 2, read clears
    chan_in[0].carrier <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk("irq", 8'h01, {7'h00, irq});
    rchk(7'h3A, 8'h04);
    rchk(7'h3A, 8'h00);
    chk("irq", 8'h00, {7'h00, irq});
    $display("test carrier done");
    // Timer and pool ready on channel B
    @(posedge clock);
    chan_in[1].timer_expiry <= 1'b1;
    chan_in[1].pool_ready <= 1'b1;
    @(posedge clock);
    chan_in[1].timer_expiry <= 1'b0;
    chan_in[1].pool_ready <= 1'b0;
    rchk(7'h7B, 8'h09);
    rchk(7'h7B, 8'h00);
    // Vector output clears pool ready
    chan_in[0].pool_ready <= 1'b1;
    @(posedge clock);
    chan_in[0].pool_ready <= 1'b0;
    ack <= 1'b1;
    @(posedge clock);
    ack <= 1'b0;
    #1 chk("vec_valid", 8'h01, {7'h00, vec_valid});
    chk("vec", 8'h08, vec);
    rchk(7'h3B, 8'h00);
    $display("test transmit done");
    // Masked with visibility: flag, no irq, no summary
    host_model_i.wr(7'h38, 8'h01);
    host_model_i.wr(7'h34, 8'hFF);
    chan_in[0].carrier <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk("irq", 8'h00, {7'h00, irq});
    rchk(7'h39, 8'h00);
    rchk(7'h3A, 8'h04);
    // Masked without visibility: not flagged
    host_model_i.wr(7'h38, 8'h00);
    chan_in[0].carrier <= 1'b1;
    repeat (2) @(posedge clock);
    rchk(7'h3A, 8'h00);
    $display("test mask done");
    // Frame start after two bytes, status byte pushed at frame end
    host_model_i.wr(7'h34, 8'h00);
    chan_in[0].header <= 8'h5A;
    chan_in[0].frame_status <= 8'hA5;
    chan_in[0].start_detect <= 1'b1;
    @(posedge clock);
    chan_in[0].start_detect <= 1'b0;
    chan_in[0].byte_valid <= 1'b1;
    repeat (2) @(posedge clock);
    chan_in[0].byte_valid <= 1'b0;
    chan_in[0].frame_end <= 1'b1;
    @(posedge clock);
    chan_in[0].frame_end <= 1'b0;
    #1 chk("fifo_data", 8'hA5, chan_out[0].fifo_data);
    chk("hdr_copy", 8'h5A, chan_out[0].hdr_copy);
    rchk(7'h3A, 8'hC0);
    $display("test frame done");
    // Loop mode: go-on-loop then poll end sets on-loop and flags bits 7, 6
    host_model_i.wr(7'h30, 8'h04);
    chan_in[0].go_on_loop <= 1'b1;
    @(posedge clock);
    chan_in[0].go_on_loop <= 1'b0;
    chan_in[0].poll_end_rx <= 1'b1;
    @(posedge clock);
    chan_in[0].poll_end_rx <= 1'b0;
    rchk(7'h3B, 8'hC0);
    chk("on_loop", 8'h01, {7'h00, chan_out[0].on_loop});
    $display("test loop done");
    end_of_test();
  end
endmodule : testbench
